/* File: spe_pkg.sv */
package spe_pkg;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS_COMMAND = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_DATA = 8'h03;
    localparam logic [7:0] OP_WRITE_DATA = 8'h02;

    // ------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_WEL_POS = 1;
    localparam int STAT_BP_LSB = 2;
    localparam int STAT_BP_MSB = 3;
    localparam int STAT_PROTECT_PIN_ENABLE_BIT_POS = 7;
    localparam logic [2:0] STAT_ZERO_BITS = 3'h0;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // ------------------------------------------------------------
    // Framing constants
    // ------------------------------------------------------------
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
    localparam logic [2:0] FIRST_DATA_BYTE = 3'h3;
    localparam logic [2:0] STATUS_DATA_BYTE = 3'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_KHZ = 125000;
    localparam int unsigned T_WRITE_CYCLE_MS = 5;
    localparam int unsigned WRITE_CYCLE_CYC = T_WRITE_CYCLE_MS * SYS_CLK_KHZ;
    localparam int CNT_W = 20;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } spe_wstate_t;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [6:0] shreg;
        logic [7:0] opcode;
        logic load;
    } spe_rx_t;

    typedef struct packed {
        logic tgl;
        logic [7:0] op;
        logic [7:0] data;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
    } spe_evt_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic wp_s1;
        logic wp_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_prev;
        logic pend_valid;
        logic [7:0] pend_op;
        logic [7:0] pend_data;
        logic pin_prot_en;
        logic [1:0] bp;
        logic wel;
        spe_wstate_t state;
        logic [CNT_W-1:0] cnt;
    } spe_sys_t;

endpackage

/* File: spe_eeprom_link.sv */
`timescale 1ns/1ps
module spe_eeprom_link #(
    parameter int unsigned WC_CYCLES = spe_pkg::WRITE_CYCLE_CYC
) (
    // System clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Serial link from the host
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    // Serial output pin
    output logic o_so,
    output logic o_so_oe,
    // Status view
    output logic [7:0] o_status,
    output logic o_busy
);

    initial
    begin
        if (WC_CYCLES < 1 || WC_CYCLES >= (1 << spe_pkg::CNT_W))
            $error("WC_CYCLES out of range");
    end

    localparam logic [spe_pkg::CNT_W-1:0] WC_LAST = spe_pkg::CNT_W'(WC_CYCLES - 1);

    spe_pkg::spe_rx_t rx_q, rx_d;
    spe_pkg::spe_evt_t evt_q, evt_d;
    logic [7:0] tx_q, tx_d;
    spe_pkg::spe_sys_t s_q, s_d;
    logic [7:0] status;
    logic cs_rise;
    logic tg_evt;
    logic eff_valid;
    logic [7:0] eff_op;
    logic [7:0] eff_data;
    logic wp_block;

    // ------------------------------------------------------------
    // Receive side, rising edge of the link clock
    // ------------------------------------------------------------

    // Shift in bits; pause freezes every counter so the frame resumes in place
    always_comb
    begin
        logic [7:0] rx_byte;
        rx_byte = {rx_q.shreg, i_si};
        rx_d = rx_q;
        evt_d = evt_q;
        evt_d.st_s1 = status;
        evt_d.st_s2 = evt_q.st_s1;
        if (i_hold_n)
        begin
            rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
            rx_d.shreg = rx_byte[6:0];
            rx_d.load = 1'b0;
            if (rx_q.bit_cnt == spe_pkg::LAST_BIT)
            begin
                if (rx_q.byte_cnt != spe_pkg::BYTE_CNT_MAX)
                    rx_d.byte_cnt = rx_q.byte_cnt + 3'h1;
                if (rx_q.byte_cnt == 3'h0)
                begin
                    rx_d.opcode = rx_byte;
                    rx_d.load = (rx_byte == spe_pkg::OP_READ_STATUS_COMMAND);
                    if (rx_byte == spe_pkg::OP_WRITE_ENABLE || rx_byte == spe_pkg::OP_WRITE_DISABLE)
                    begin
                        evt_d.tgl = ~evt_q.tgl;
                        evt_d.op = rx_byte;
                        evt_d.data = 8'h00;
                    end
                end
                else
                begin
                    rx_d.load = (rx_q.opcode == spe_pkg::OP_READ_STATUS_COMMAND);
                    if ((rx_q.opcode == spe_pkg::OP_WRITE_STATUS && rx_q.byte_cnt == spe_pkg::STATUS_DATA_BYTE)
                        || (rx_q.opcode == spe_pkg::OP_WRITE_DATA && rx_q.byte_cnt >= spe_pkg::FIRST_DATA_BYTE))
                    begin
                        evt_d.tgl = ~evt_q.tgl;
                        evt_d.op = rx_q.opcode;
                        evt_d.data = rx_byte;
                    end
                end
            end
        end
    end

    // Frame state clears whenever select is high
    always_ff @(posedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
            rx_q <= '0;
        else
            rx_q <= rx_d;
    end

    // Event word and status copy outlive the frame, so they reset only with the system
    always_ff @(posedge i_sck or negedge i_reset_n)
    begin
        if (!i_reset_n)
            evt_q <= '0;
        else
            evt_q <= evt_d;
    end

    // ------------------------------------------------------------
    // Transmit side, falling edge of the link clock
    // ------------------------------------------------------------

    // Status copy is quasi-static, so passing its bits through two link-clock stages as a byte is safe enough
    always_comb
    begin
        tx_d = tx_q;
        if (i_hold_n)
        begin
            if (rx_q.load)
                tx_d = evt_q.st_s2;
            else
                tx_d = {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
            tx_q <= 8'h00;
        else
            tx_q <= tx_d;
    end

    // Pin driven only while selected and not paused
    assign o_so = tx_q[7];
    assign o_so_oe = !i_cs_n && i_hold_n;

    // ------------------------------------------------------------
    // System side: command apply and write cycle timer
    // ------------------------------------------------------------
    assign status = {s_q.pin_prot_en, spe_pkg::STAT_ZERO_BITS, s_q.bp, s_q.wel,
                     (s_q.state == spe_pkg::ST_BUSY)};
    assign cs_rise = s_q.cs_s2 && !s_q.cs_prev;
    assign tg_evt = s_q.tg_s2 ^ s_q.tg_prev;
    // Event seen in the same cycle as the select rise still counts
    assign eff_valid = s_q.pend_valid || (tg_evt && s_q.state == spe_pkg::ST_IDLE);
    assign eff_op = tg_evt ? evt_q.op : s_q.pend_op;
    assign eff_data = tg_evt ? evt_q.data : s_q.pend_data;
    assign wp_block = !s_q.wp_s2 && s_q.pin_prot_en;

    // Commands take effect only at the end of the frame, after the last full byte
    always_comb
    begin
        s_d = s_q;
        s_d.cs_s1 = i_cs_n;
        s_d.cs_s2 = s_q.cs_s1;
        s_d.cs_prev = s_q.cs_s2;
        s_d.wp_s1 = i_wp_n;
        s_d.wp_s2 = s_q.wp_s1;
        s_d.tg_s1 = evt_q.tgl;
        s_d.tg_s2 = s_q.tg_s1;
        s_d.tg_prev = s_q.tg_s2;
        if (tg_evt && s_q.state == spe_pkg::ST_IDLE)
        begin
            s_d.pend_valid = 1'b1;
            s_d.pend_op = evt_q.op;
            s_d.pend_data = evt_q.data;
        end
        case (s_q.state)
            spe_pkg::ST_IDLE:
            begin
                if (cs_rise)
                begin
                    s_d.pend_valid = 1'b0;
                    if (eff_valid)
                    begin
                        case (eff_op)
                            spe_pkg::OP_WRITE_ENABLE: s_d.wel = 1'b1;
                            spe_pkg::OP_WRITE_DISABLE: s_d.wel = 1'b0;
                            spe_pkg::OP_WRITE_STATUS:
                            begin
                                if (s_q.wel && !wp_block)
                                begin
                                    s_d.pin_prot_en = eff_data[spe_pkg::STAT_PROTECT_PIN_ENABLE_BIT_POS];
                                    s_d.bp = eff_data[spe_pkg::STAT_BP_MSB:spe_pkg::STAT_BP_LSB];
                                    s_d.state = spe_pkg::ST_BUSY;
                                    s_d.cnt = '0;
                                end
                            end
                            spe_pkg::OP_WRITE_DATA:
                            begin
                                if (s_q.wel)
                                begin
                                    s_d.state = spe_pkg::ST_BUSY;
                                    s_d.cnt = '0;
                                end
                            end
                            default: s_d.wel = s_q.wel;
                        endcase
                    end
                end
            end
            spe_pkg::ST_BUSY:
            begin
                // Counter ends exactly at the write cycle time; latch drops with it
                s_d.pend_valid = 1'b0;
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == WC_LAST)
                begin
                    s_d.state = spe_pkg::ST_IDLE;
                    s_d.wel = 1'b0;
                    s_d.cnt = '0;
                end
            end
            default: s_d.state = spe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q <= '0;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.cs_prev <= 1'b1;
            s_q.state <= spe_pkg::ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign o_status = status;
    assign o_busy = (s_q.state == spe_pkg::ST_BUSY);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_wc_bound;
        @(posedge i_sys_clk) disable iff (!i_reset_n) o_busy |-> (s_q.cnt <= WC_LAST);
    endproperty
    a_wc_bound: assert property (p_wc_bound) else $error("write cycle overran");

    property p_wc_end;
        @(posedge i_sys_clk) disable iff (!i_reset_n) $fell(o_busy) |-> ($past(s_q.cnt) == WC_LAST) && !o_status[1];
    endproperty
    a_wc_end: assert property (p_wc_end) else $error("write cycle ended early");

    property p_busy_bit;
        @(posedge i_sys_clk) disable iff (!i_reset_n) o_status[spe_pkg::STAT_BUSY_POS] == o_busy;
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit mismatch");

    property p_pe_pos;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            o_status[spe_pkg::STAT_PROTECT_PIN_ENABLE_BIT_POS] == s_q.pin_prot_en;
    endproperty
    a_pe_pos: assert property (p_pe_pos) else $error("enable bit misplaced");

    property p_sr_blocked;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            (cs_rise && eff_valid && !o_busy && eff_op == spe_pkg::OP_WRITE_STATUS && wp_block)
            |=> $stable(o_status[7:2]) && !o_busy;
    endproperty
    a_sr_blocked: assert property (p_sr_blocked) else $error("status write not blocked");

    property p_sr_allowed;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            (cs_rise && eff_valid && !o_busy && eff_op == spe_pkg::OP_WRITE_STATUS && s_q.wp_s2 && s_q.wel)
            |=> o_busy;
    endproperty
    a_sr_allowed: assert property (p_sr_allowed) else $error("status write wrongly blocked");

    property p_busy_ignore;
        @(posedge i_sys_clk) disable iff (!i_reset_n) (o_busy && $past(o_busy) && cs_rise) |=> $stable(o_status[7:2]);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

    property p_cs_hiz;
        @(posedge i_sys_clk) disable iff (!i_reset_n) i_cs_n |-> !o_so_oe;
    endproperty
    a_cs_hiz: assert property (p_cs_hiz) else $error("output driven while deselected");

    property p_hold_hiz;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !i_hold_n |-> !o_so_oe;
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) else $error("output driven while paused");

    property p_hold_keep;
        @(posedge i_sck) disable iff (i_cs_n) !i_hold_n |=> $stable(rx_q.bit_cnt) && $stable(rx_q.byte_cnt);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("progress lost during pause");

    property p_rise_sample;
        @(posedge i_sck) disable iff (i_cs_n) (i_hold_n && rx_q.bit_cnt != spe_pkg::LAST_BIT) |=> rx_q.shreg[0] == $past(i_si);
    endproperty
    a_rise_sample: assert property (p_rise_sample) else $error("input not sampled on rise");

    c_write: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) $rose(o_busy));
    c_wel: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) $rose(o_status[1]));
    c_blocked: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        cs_rise && eff_valid && eff_op == spe_pkg::OP_WRITE_STATUS && wp_block);
    c_pause: cover property (@(posedge i_sck) disable iff (i_cs_n) !i_hold_n);

endmodule

/* File: spe_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module spe_host_model (
    // Serial link to the device
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    output logic o_hold_n,
    // Output pin as seen on the wire
    input wire logic i_so_wire,
    input wire logic i_so_oe
);
    // Idle levels; the clock stands still outside frames
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end

    // One frame, MSB first; rx keeps the last eight bits sampled on rising edges
    task automatic frame(input logic [7:0] tx [4], input int n, input bit mode3, input int pbit,
                         output logic [7:0] rx, output logic oe_paused);
        oe_paused = 1'b0;
        rx = 8'h00;
        o_sck = mode3;
        #6 o_cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++)
        begin
            #6 o_sck = 1'b0;
            o_si = tx[i / 8][7 - i % 8];
            if (i == pbit)
            begin
                // Clock held low at both pause edges; stray clocks meanwhile must not count
                #3 o_hold_n = 1'b0;
                repeat (2)
                begin
                    #6 o_sck = 1'b1;
                    oe_paused = oe_paused | i_so_oe;
                    o_si = ~o_si;
                    #6 o_sck = 1'b0;
                end
                o_si = tx[i / 8][7 - i % 8];
                #3 o_hold_n = 1'b1;
            end
            #6 o_sck = 1'b1;
            rx = {rx[6:0], i_so_wire};
        end
        #6 o_sck = mode3;
        #6 o_cs_n = 1'b1;
        // Released line shows a changed level, not the last bit
        o_si = ~o_si;
    endtask
endmodule

/* File: spe_eeprom_link_tb_top.sv */
`timescale 1ns/1ps
module spe_eeprom_link_tb_top;
    // Short write cycle keeps the run brief
    localparam int WC = 50;
    logic sys_clk;
    logic reset_n;
    logic wp_n;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe;
    wire so_wire;
    logic [7:0] status;
    logic busy;
    int err_count = 0;
    int n_compared = 0;
    logic [15:0] lfsr_q = 16'h0010;
    logic [7:0] rx;
    logic oe_p;
    logic [7:0] tx [4];

    // ----------------------------------------
    // Design, host and wire
    // ----------------------------------------
    assign so_wire = so_oe ? so : 1'bz;
    spe_eeprom_link #(.WC_CYCLES(WC)) dut_u (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
        .o_status(status), .o_busy(busy));
    spe_host_model host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
        .i_so_wire(so_wire), .i_so_oe(so_oe));

    // 125 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [7:0] exp_status(input logic pe, input logic [1:0] bp, input logic wel,
                                              input logic bsy);
        return {pe, 3'h0, bp, wel, bsy};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic rnd;
        lfsr_q = lfsr_next(lfsr_q);
    endtask

    // Frame, then give the select rise time to cross into the system domain
    task automatic send(input logic [7:0] a, b, c, d, input int n, input bit m, input int p);
        tx[0] = a;
        tx[1] = b;
        tx[2] = c;
        tx[3] = d;
        host_u.frame(tx, n, m, p, rx, oe_p);
        repeat (10) @(posedge sys_clk);
    endtask

    // Bounded wait for the write cycle to end
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < WC + 20)
        begin
            @(posedge sys_clk);
            k++;
        end
    endtask

    task automatic give_verdict;
        $display("Counts: compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        wp_n = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Scaled-down power-up wait before the first frame
        repeat (5) @(posedge sys_clk);
        check(status, 8'h00);
        check({7'h00, so_oe}, 8'h00);
        // Write enable, then status read in both modes
        send(spe_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1, 1'b0, -1);
        check(status, exp_status(1'b0, 2'h0, 1'b1, 1'b0));
        for (int m = 0; m < 2; m++)
        begin
            rnd();
            send(spe_pkg::OP_READ_STATUS_COMMAND, lfsr_q[7:0], 8'h00, 8'h00, 2, m[0], -1);
            check(rx, 8'h02);
            check({7'h00, so_oe}, 8'h00);
        end
        // Paused read keeps its place; output floats while paused
        send(spe_pkg::OP_READ_STATUS_COMMAND, 8'h00, 8'h00, 8'h00, 2, 1'b0, 3);
        check(rx, 8'h02);
        check({7'h00, oe_p}, 8'h00);
        // Accepted status write, read and disable attempt while busy
        send(spe_pkg::OP_WRITE_STATUS, 8'h8C, 8'h00, 8'h00, 2, 1'b1, -1);
        check({7'h00, busy}, 8'h01);
        send(spe_pkg::OP_WRITE_DISABLE, 8'h00, 8'h00, 8'h00, 1, 1'b0, -1);
        send(spe_pkg::OP_READ_STATUS_COMMAND, 8'h00, 8'h00, 8'h00, 2, 1'b1, -1);
        check(rx & 8'h03, 8'h03);
        wait_idle();
        check({7'h00, busy}, 8'h00);
        check(status, exp_status(1'b1, 2'h3, 1'b0, 1'b0));
        // Pin low with enable bit set refuses the status write
        @(posedge sys_clk) wp_n <= 1'b0;
        send(spe_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1, 1'b0, -1);
        send(spe_pkg::OP_WRITE_STATUS, 8'h00, 8'h00, 8'h00, 2, 1'b0, -1);
        check({7'h00, busy}, 8'h00);
        check(status, exp_status(1'b1, 2'h3, 1'b1, 1'b0));
        // Pin high lets the same write through
        @(posedge sys_clk) wp_n <= 1'b1;
        send(spe_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1, 1'b1, -1);
        send(spe_pkg::OP_WRITE_STATUS, 8'h00, 8'h00, 8'h00, 2, 1'b1, -1);
        check({7'h00, busy}, 8'h01);
        wait_idle();
        check(status, 8'h00);
        // Random data writes, random mode, one paused mid-address
        for (int j = 0; j < 3; j++)
        begin
            rnd();
            send(spe_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1, lfsr_q[0], -1);
            send(spe_pkg::OP_WRITE_DATA, {4'h0, lfsr_q[11:8]}, lfsr_q[7:0], lfsr_q[15:8], 4, lfsr_q[1],
                 j == 1 ? 13 : -1);
            check({7'h00, busy}, 8'h01);
            wait_idle();
            check({7'h00, busy}, 8'h00);
            check(status, 8'h00);
        end
        give_verdict();
    end
endmodule
